/* File: rtl/ppc_map.svh */
// Register map, field positions and reset values of the power state control
`ifndef PPC_MAP_SVH
`define PPC_MAP_SVH

// Register byte offsets
`define PPC_ADDR_STATUS 8'h00
`define PPC_ADDR_MASK   8'h04
`define PPC_ADDR_CTRL   8'h08
`define PPC_ADDR_LEVELS 8'h0c
`define PPC_ADDR_CLAMPS 8'h10

// Status flag positions
`define PPC_ST_OC   0
`define PPC_ST_OT   1
`define PPC_ST_UV   2
`define PPC_ST_DONE 3
`define PPC_NFLAGS  4

// Control field positions
`define PPC_CTRL_GO    0
`define PPC_MODE_LO    1
`define PPC_MODE_HI    2
`define PPC_CTRL_ACT   3
`define PPC_CTRL_LOOP  4
`define PPC_PIN_LO     5
`define PPC_PIN_HI     6
`define PPC_CTRL_BRK   7
`define PPC_CTRL_OLB   8
`define PPC_CTRL_SHAPE 9
`define PPC_UVTH_LO    10
`define PPC_UVTH_HI    12
`define PPC_CTRL_W     13

// Reset values
`define PPC_CTRL_RST   13'h0000
`define PPC_MASK_RST   4'h0
`define PPC_LEVELS_RST 16'h0000
`define PPC_CLAMPS_RST 24'hffffff

`endif

/* File: rtl/ppc_pkg.sv */
// Types of the power state control block
package ppc_pkg;
    typedef enum logic [1:0] {
        PPC_MODE_REALTIME,
        PPC_MODE_SEQUENCER,
        PPC_MODE_DIAG,
        PPC_MODE_CAL
    } ppc_mode_t;

    typedef enum logic [1:0] {
        PPC_PIN_PULSE,
        PPC_PIN_LEVEL,
        PPC_PIN_IRQ,
        PPC_PIN_BAD
    } ppc_pin_t;

    typedef enum {
        PPC_OFF,
        PPC_STANDBY,
        PPC_CHECK,
        PPC_RUN,
        PPC_BRAKE
    } ppc_state_t;
endpackage

/* File: rtl/ppc_top.sv */
// Power state and process control with APB registers and interrupt pin
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ppc_map.svh"

module ppc_top (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        pinIn,
    output logic             pinOut,
    output logic             pinOe,
    input  wire logic        overCurrent,
    input  wire logic        overTemp,
    input  wire logic        uvDetect,
    input  wire logic [7:0]  supplyLevel,
    input  wire logic        bemfMoving,
    input  wire logic        routineFinished,
    output logic             runEn,
    output logic             brakeEn,
    output logic      [1:0]  processSel,
    output logic      [7:0]  clampLevel,
    output logic      [2:0]  uvThreshold
);

    ppc_pkg::ppc_state_t st_r, st_nxt;
    logic [`PPC_CTRL_W-1:0]  ctrl_r, ctrl_nxt;
    logic [`PPC_NFLAGS-1:0]  mask_r, mask_nxt;
    logic [`PPC_NFLAGS-1:0]  status_r, status_nxt;
    logic [15:0]             levels_r, levels_nxt;
    logic [23:0]             clamps_r, clamps_nxt;
    logic                    pinPrev_r;
    logic [31:0]             prdata_r, prdata_nxt;
    logic                    pready_r, pready_nxt;
    logic                    pslverr_r, pslverr_nxt;
    logic                    pinOe_r, pinOe_nxt;
    logic                    pinOut_r;
    logic                    runEn_r, brakeEn_r;
    logic [1:0]              processSel_r;
    logic [7:0]              clampLevel_r, clampLevel_nxt;
    logic                    wrEn, rdEn, cfgChange, active;
    logic                    ocSet, otSet, uvSet, crit, brakeWanted;
    logic                    pinRise;
    ppc_pkg::ppc_mode_t      modeSel;
    ppc_pkg::ppc_pin_t       pinFunc, pinFuncNew;

    // Decoded fields
    assign modeSel    = ppc_pkg::ppc_mode_t'(ctrl_r[`PPC_MODE_HI:`PPC_MODE_LO]);
    assign pinFunc    = ppc_pkg::ppc_pin_t'(ctrl_r[`PPC_PIN_HI:`PPC_PIN_LO]);
    assign pinFuncNew = ppc_pkg::ppc_pin_t'(pwdata[`PPC_PIN_HI:`PPC_PIN_LO]);

    // Completing access: the edge where pready is seen high
    assign wrEn = psel && penable && pready_r && pwrite;
    assign rdEn = psel && penable && pready_r && !pwrite;

    // Mode settings compared as one span, go and threshold excluded
    assign cfgChange = wrEn && (paddr == `PPC_ADDR_CTRL) &&
        (pwdata[`PPC_CTRL_SHAPE:`PPC_MODE_LO] != ctrl_r[`PPC_CTRL_SHAPE:`PPC_MODE_LO]);

    assign active = (st_r == ppc_pkg::PPC_CHECK) || (st_r == ppc_pkg::PPC_RUN) ||
                    (st_r == ppc_pkg::PPC_BRAKE);

    // Fault monitors; undervoltage and temperature also watched during bus use
    assign ocSet = overCurrent && active;
    assign otSet = overTemp && (active || psel);
    assign uvSet = uvDetect && (active || psel);
    assign crit  = active && (overCurrent || overTemp || uvDetect);

    // Braking needs motion, and open loop needs its own enable
    assign brakeWanted = ctrl_r[`PPC_CTRL_BRK] && bemfMoving &&
        (ctrl_r[`PPC_CTRL_LOOP] || ctrl_r[`PPC_CTRL_OLB]) &&
        (modeSel != ppc_pkg::PPC_MODE_CAL);

    assign pinRise = pinIn && !pinPrev_r;

    // Register writes, trigger handling and the power state machine
    always_comb begin
        ctrl_nxt   = ctrl_r;
        mask_nxt   = mask_r;
        levels_nxt = levels_r;
        clamps_nxt = clamps_r;
        status_nxt = status_r;
        st_nxt     = st_r;
        // Writes accepted in every state, standby included
        if (wrEn) begin
            case (paddr)
                `PPC_ADDR_MASK: mask_nxt = pwdata[`PPC_NFLAGS-1:0];
                `PPC_ADDR_CTRL: begin
                    ctrl_nxt = pwdata[`PPC_CTRL_W-1:0];
                    // Unused fourth code keeps the old pin function
                    if (pinFuncNew == ppc_pkg::PPC_PIN_BAD) begin
                        ctrl_nxt[`PPC_PIN_HI:`PPC_PIN_LO] = ctrl_r[`PPC_PIN_HI:`PPC_PIN_LO];
                    end
                end
                `PPC_ADDR_LEVELS: levels_nxt = pwdata[15:0];
                `PPC_ADDR_CLAMPS: clamps_nxt = pwdata[23:0];
                default: ;
            endcase
        end
        // Pin as trigger: a rising edge toggles, a level follows the pin
        if (pinFunc == ppc_pkg::PPC_PIN_PULSE && pinRise) begin
            ctrl_nxt[`PPC_CTRL_GO] = !ctrl_r[`PPC_CTRL_GO];
        end else if (pinFunc == ppc_pkg::PPC_PIN_LEVEL && pinIn != pinPrev_r) begin
            ctrl_nxt[`PPC_CTRL_GO] = pinIn;
        end
        // Read clears only the bits that were shown, so a new event survives
        if (rdEn && paddr == `PPC_ADDR_STATUS) begin
            status_nxt = status_r & ~prdata_r[`PPC_NFLAGS-1:0];
        end
        status_nxt[`PPC_ST_OC] = status_nxt[`PPC_ST_OC] | ocSet;
        status_nxt[`PPC_ST_OT] = status_nxt[`PPC_ST_OT] | otSet;
        status_nxt[`PPC_ST_UV] = status_nxt[`PPC_ST_UV] | uvSet;
        case (st_r)
            ppc_pkg::PPC_OFF: begin
                st_nxt = ppc_pkg::PPC_STANDBY;
            end
            ppc_pkg::PPC_STANDBY: begin
                // Wake into the entry check before the selected process
                if (ctrl_r[`PPC_CTRL_GO]) begin
                    st_nxt = ppc_pkg::PPC_CHECK;
                end
            end
            ppc_pkg::PPC_CHECK: begin
                if (crit || cfgChange) begin
                    st_nxt = ppc_pkg::PPC_STANDBY;
                    ctrl_nxt[`PPC_CTRL_GO] = 1'b0;
                end else begin
                    st_nxt = ppc_pkg::PPC_RUN;
                end
            end
            ppc_pkg::PPC_RUN: begin
                if (crit) begin
                    st_nxt = ppc_pkg::PPC_STANDBY;
                    ctrl_nxt[`PPC_CTRL_GO] = 1'b0;
                end else if (cfgChange) begin
                    st_nxt = ppc_pkg::PPC_STANDBY;
                    ctrl_nxt[`PPC_CTRL_GO] = 1'b0;
                end else if (!ctrl_r[`PPC_CTRL_GO]) begin
                    st_nxt = brakeWanted ? ppc_pkg::PPC_BRAKE : ppc_pkg::PPC_STANDBY;
                end else if (routineFinished && modeSel != ppc_pkg::PPC_MODE_REALTIME) begin
                    status_nxt[`PPC_ST_DONE] = 1'b1;
                    ctrl_nxt[`PPC_CTRL_GO] = 1'b0;
                    st_nxt = brakeWanted ? ppc_pkg::PPC_BRAKE : ppc_pkg::PPC_STANDBY;
                end
            end
            ppc_pkg::PPC_BRAKE: begin
                // Faults cut the brake short
                if (crit || !bemfMoving) begin
                    st_nxt = ppc_pkg::PPC_STANDBY;
                end
            end
            default: st_nxt = ppc_pkg::PPC_STANDBY;
        endcase
    end

    // Battery preservation picks the tighter clamp
    always_comb begin
        if (supplyLevel < levels_r[15:8]) begin
            clampLevel_nxt = clamps_r[23:16];
        end else if (supplyLevel < levels_r[7:0]) begin
            clampLevel_nxt = clamps_r[15:8];
        end else begin
            clampLevel_nxt = clamps_r[7:0];
        end
    end

    // Interrupt pin, only pulled low in interrupt function
    always_comb begin
        pinOe_nxt = (pinFunc == ppc_pkg::PPC_PIN_IRQ) &&
                    (|(status_r & ~mask_r));
    end

    // APB answer: data and ready prepared in the setup cycle, no wait states
    always_comb begin
        prdata_nxt  = 32'h0000_0000;
        pready_nxt  = 1'b0;
        pslverr_nxt = 1'b0;
        if (psel && !penable) begin
            pready_nxt = 1'b1;
            case (paddr)
                `PPC_ADDR_STATUS: prdata_nxt[`PPC_NFLAGS-1:0] = status_r;
                `PPC_ADDR_MASK:   prdata_nxt[`PPC_NFLAGS-1:0] = mask_r;
                `PPC_ADDR_CTRL:   prdata_nxt[`PPC_CTRL_W-1:0] = ctrl_r;
                `PPC_ADDR_LEVELS: prdata_nxt[15:0] = levels_r;
                `PPC_ADDR_CLAMPS: prdata_nxt[23:0] = clamps_r;
                default:          pslverr_nxt = 1'b1;
            endcase
        end
    end

    // Shutdown reset loads every reset value and aborts any process
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r         <= ppc_pkg::PPC_OFF;
            ctrl_r       <= `PPC_CTRL_RST;
            mask_r       <= `PPC_MASK_RST;
            status_r     <= '0;
            levels_r     <= `PPC_LEVELS_RST;
            clamps_r     <= `PPC_CLAMPS_RST;
            pinPrev_r    <= 1'b1;                     // Pin idles high, so no false edge
            prdata_r     <= 32'h0000_0000;
            pready_r     <= 1'b0;
            pslverr_r    <= 1'b0;
            pinOe_r      <= 1'b0;
            pinOut_r     <= 1'b0;
            runEn_r      <= 1'b0;
            brakeEn_r    <= 1'b0;
            processSel_r <= 2'h0;
            clampLevel_r <= 8'hff;
        end else begin
            st_r         <= st_nxt;
            ctrl_r       <= ctrl_nxt;
            mask_r       <= mask_nxt;
            status_r     <= status_nxt;
            levels_r     <= levels_nxt;
            clamps_r     <= clamps_nxt;
            pinPrev_r    <= pinIn;
            prdata_r     <= prdata_nxt;
            pready_r     <= pready_nxt;
            pslverr_r    <= pslverr_nxt;
            pinOe_r      <= pinOe_nxt;
            pinOut_r     <= 1'b0;                     // Open drain only ever pulls low
            runEn_r      <= (st_nxt == ppc_pkg::PPC_RUN);
            brakeEn_r    <= (st_nxt == ppc_pkg::PPC_BRAKE);
            processSel_r <= ctrl_nxt[`PPC_MODE_HI:`PPC_MODE_LO];
            clampLevel_r <= clampLevel_nxt;
        end
    end

    // Output ports straight from flops
    assign prdata      = prdata_r;
    assign pready      = pready_r;
    assign pslverr     = pslverr_r;
    assign pinOut      = pinOut_r;
    assign pinOe       = pinOe_r;
    assign runEn       = runEn_r;
    assign brakeEn     = brakeEn_r;
    assign processSel  = processSel_r;
    assign clampLevel  = clampLevel_r;
    assign uvThreshold = ctrl_r[`PPC_UVTH_HI:`PPC_UVTH_LO];

    // Checks
    chk_pin_opendrain: assert property (@(posedge clk) disable iff (rst)
        pinOe_r |-> (pinOut_r == 1'b0) && $past(pinFunc == ppc_pkg::PPC_PIN_IRQ))
        else $error("pin driven outside interrupt function");

    chk_irq_hold: assert property (@(posedge clk) disable iff (rst)
        (pinFunc == ppc_pkg::PPC_PIN_IRQ && status_r[`PPC_ST_OC] && !mask_r[`PPC_ST_OC]
         && !rdEn && !wrEn) |=> pinOe_r)
        else $error("interrupt pin not held low");

    chk_oc_flag: assert property (@(posedge clk) disable iff (rst)
        (overCurrent && active) |=> status_r[`PPC_ST_OC])
        else $error("over-current flag missed");

    chk_ot_flag: assert property (@(posedge clk) disable iff (rst)
        (overTemp && st_r == ppc_pkg::PPC_RUN) |=> status_r[`PPC_ST_OT])
        else $error("over-temperature flag missed");

    chk_uv_flag: assert property (@(posedge clk) disable iff (rst)
        (uvDetect && (active || psel)) |=> status_r[`PPC_ST_UV])
        else $error("undervoltage flag missed");

    chk_rt_nodone: assert property (@(posedge clk) disable iff (rst)
        $rose(status_r[`PPC_ST_DONE]) |-> $past(modeSel) != ppc_pkg::PPC_MODE_REALTIME)
        else $error("done flag from realtime playback");

    chk_standby_quiet: assert property (@(posedge clk) disable iff (rst)
        (st_r == ppc_pkg::PPC_STANDBY && !psel && !status_r[`PPC_ST_OT]
         && !status_r[`PPC_ST_OC]) |=> !status_r[`PPC_ST_OT] && !status_r[`PPC_ST_OC])
        else $error("fault flagged in idle standby");

    chk_uv_nobrake: assert property (@(posedge clk) disable iff (rst)
        (st_r == ppc_pkg::PPC_RUN && uvDetect) |=> !brakeEn_r && !runEn_r
        && st_r == ppc_pkg::PPC_STANDBY)
        else $error("undervoltage did not stop at once");

    chk_wake: assert property (@(posedge clk) disable iff (rst)
        (st_r == ppc_pkg::PPC_STANDBY && ctrl_r[`PPC_CTRL_GO] && !overCurrent && !overTemp
         && !uvDetect) ##1 (!overCurrent && !overTemp && !uvDetect && !cfgChange)
        |=> runEn_r)
        else $error("trigger did not wake playback");

    chk_pin_release: assert property (@(posedge clk) disable iff (rst)
        !(|(status_r & ~mask_r)) |=> !pinOe_r)
        else $error("interrupt pin not released");

    chk_done_set: assert property (@(posedge clk) disable iff (rst)
        (st_r == ppc_pkg::PPC_RUN && routineFinished && ctrl_r[`PPC_CTRL_GO] && !crit
         && !cfgChange && modeSel != ppc_pkg::PPC_MODE_REALTIME) |=> status_r[`PPC_ST_DONE])
        else $error("done flag not set on finish");

    chk_abort_nodone: assert property (@(posedge clk) disable iff (rst)
        (active && (crit || cfgChange) && !status_r[`PPC_ST_DONE])
        |=> !status_r[`PPC_ST_DONE])
        else $error("done flag set by an aborted process");

    chk_entry_fault: assert property (@(posedge clk) disable iff (rst)
        (st_r == ppc_pkg::PPC_CHECK && crit) |=> st_r == ppc_pkg::PPC_STANDBY && !runEn_r)
        else $error("routine ran despite fault on entry");

    chk_cfg_abort: assert property (@(posedge clk) disable iff (rst)
        (st_r == ppc_pkg::PPC_RUN && cfgChange) |=> st_r == ppc_pkg::PPC_STANDBY
        && !runEn_r && !brakeEn_r && !ctrl_r[`PPC_CTRL_GO])
        else $error("setting change did not abort");

    chk_stop_brake: assert property (@(posedge clk) disable iff (rst)
        (st_r == ppc_pkg::PPC_RUN && !ctrl_r[`PPC_CTRL_GO] && !crit && !cfgChange)
        |=> brakeEn_r == $past(brakeWanted) && !runEn_r)
        else $error("stop trigger handled wrongly");

    chk_clamp_pick: assert property (@(posedge clk) disable iff (rst)
        (supplyLevel < levels_r[15:8]) |=> clampLevel_r == $past(clamps_r[23:16]))
        else $error("level two clamp not applied");

    chk_flag_sticky: assert property (@(posedge clk) disable iff (rst)
        (status_r[`PPC_ST_OC] && !rdEn) |=> status_r[`PPC_ST_OC])
        else $error("over-current flag lost without a read");

    chk_shutdown_off: assert property (@(posedge clk)
        rst |=> st_r == ppc_pkg::PPC_OFF && !runEn_r && !brakeEn_r && !pinOe_r)
        else $error("shutdown left the device active");

    chk_pin_mode: assert property (@(posedge clk) disable iff (rst)
        pinFunc != ppc_pkg::PPC_PIN_BAD)
        else $error("pin function holds the unused code");

    chk_level_follow: assert property (@(posedge clk) disable iff (rst)
        (pinFunc == ppc_pkg::PPC_PIN_LEVEL && pinIn != pinPrev_r && !wrEn
         && st_r == ppc_pkg::PPC_STANDBY) |=> ctrl_r[`PPC_CTRL_GO] == $past(pinIn))
        else $error("level trigger not followed");

    chk_pulse_toggle: assert property (@(posedge clk) disable iff (rst)
        (pinFunc == ppc_pkg::PPC_PIN_PULSE && pinIn && !pinPrev_r && !wrEn
         && st_r == ppc_pkg::PPC_STANDBY)
        |=> ctrl_r[`PPC_CTRL_GO] != $past(ctrl_r[`PPC_CTRL_GO]))
        else $error("pulse trigger did not toggle go");

endmodule // ppc_top
`default_nettype wire

/* File: verification/ppc_host_model.sv */
// Host side of the multi-function pin: pull-up resistor and trigger driver
`timescale 1ns/1ps
`default_nettype none

module ppc_host_model (
    input  wire logic pinOut,
    input  wire logic pinOe,
    input  wire logic trigOn,
    input  wire logic trigLevel,
    output logic      pinWire,
    output logic      irqSeen
);
    // Wired-AND node: device pulls low, host drives only in trigger use
    always_comb begin
        pinWire = (pinOe ? pinOut : 1'b1) & (trigOn ? trigLevel : 1'b1);
    end

    // Low node read as interrupt only while the host is listening
    assign irqSeen = !trigOn && (pinWire === 1'b0);
endmodule // ppc_host_model
`default_nettype wire

/* File: verification/ppc_top_test.sv */
// Self-checking bench of the power state and process control block
`timescale 1ns/1ps
`default_nettype none
`include "ppc_map.svh"

module ppc_top_test;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr, supplyLevel, clampLevel, s;
    logic [31:0] pwdata, prdata, rd;
    logic        pinIn, pinOut, pinOe, overCurrent, overTemp, uvDetect;
    logic        bemfMoving, routineFinished, runEn, brakeEn;
    logic        trigOn, trigLevel, irqSeen;
    logic [1:0]  processSel;
    logic [2:0]  uvThreshold;
    int          fail_count, total_checks, cycleCount, mStatus, seed, i;

    ppc_top ppc_top_inst (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut),
        .pinOe(pinOe), .overCurrent(overCurrent), .overTemp(overTemp),
        .uvDetect(uvDetect), .supplyLevel(supplyLevel), .bemfMoving(bemfMoving),
        .routineFinished(routineFinished), .runEn(runEn), .brakeEn(brakeEn),
        .processSel(processSel), .clampLevel(clampLevel), .uvThreshold(uvThreshold));
    ppc_host_model ppc_host_model_inst (.pinOut(pinOut), .pinOe(pinOe),
        .trigOn(trigOn), .trigLevel(trigLevel), .pinWire(pinIn), .irqSeen(irqSeen));

    // Free-running 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Hang guard, well above the length of the sequence
    always @(posedge clk) begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == 20000) begin
            fail_count++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("Checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chkWord(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chkBit(input logic got, input logic exp, input string what);
        chkWord({31'h0, got}, {31'h0, exp}, what);
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // No wait count assumed; only the hang guard ends a stuck wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chkWord(rd, exp, what);
    endtask

    // Model status: compare, then the read empties it
    task automatic rdStatus();
        rdChk(`PPC_ADDR_STATUS, mStatus, "status");
        mStatus = 0;
    endtask

    // sel 0 runEn, 1 brakeEn, 2 pinOe; hold=1 demands the level all along
    task automatic watch(input int sel, input logic v, input bit hold, input string what);
        logic b;
        for (int n = 0; n < 8; n++) begin
            @(posedge clk);
            b = (sel == 0) ? runEn : (sel == 1) ? brakeEn : pinOe;
            if ((b === v) != hold) break;
        end
        chkBit(b, v, what);
    endtask

    // sel 0 finish, 1 over-current, 2 undervoltage, 3 host trigger
    task automatic pulse(input int sel);
        for (int n = 1; n >= 0; n--) begin
            @(posedge clk);
            case (sel)
                0: routineFinished <= n[0];
                1: overCurrent <= n[0];
                2: uvDetect <= n[0];
                default: trigLevel <= n[0];
            endcase
        end
    endtask

    function automatic logic [31:0] cw(input logic g, input logic [1:0] m,
                                       input logic [1:0] p, input logic b);
        return {19'h0, 3'h5, 2'h0, b, p, 1'b1, 1'b0, m, g};
    endfunction

    task automatic startRun(input logic [1:0] m, input logic b);
        apb(1'b1, `PPC_ADDR_CTRL, cw(1'b1, m, 2'd2, b));
        watch(0, 1'b1, 0, "run start");
        chkWord({30'h0, processSel}, {30'h0, m}, "mode");
    endtask

    // Main sequence
    initial begin
        {psel, penable, pwrite, overCurrent, overTemp, uvDetect} = '0;
        {bemfMoving, routineFinished, trigOn, trigLevel, paddr, pwdata} = '0;
        {fail_count, total_checks, cycleCount, mStatus} = '0;
        rst = 1'b1;
        supplyLevel = 8'hff;
        seed = 32'ha6a9;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        // Defaults after power-up, refused offset
        rdStatus();
        rdChk(`PPC_ADDR_MASK, 32'h0, "mask");
        rdChk(`PPC_ADDR_CTRL, 32'h0, "ctrl");
        rdChk(`PPC_ADDR_CLAMPS, 32'hffffff, "clamps");
        apb(1'b0, 8'h14, 32'h0);
        chkBit(err, 1'b1, "unmapped");
        $display("Test done: defaults");
        // Clamp choice per supply, boundaries first then random codes
        apb(1'b1, `PPC_ADDR_LEVELS, 32'h4080);
        apb(1'b1, `PPC_ADDR_CLAMPS, 32'h305070);
        for (i = 0; i < 8; i++) begin
            s = (i == 0) ? 8'h40 : (i == 1) ? 8'h80 : 8'($random(seed));
            supplyLevel <= s;
            repeat (3) @(posedge clk);
            chkWord(clampLevel, (s < 8'h40) ? 8'h30 : (s < 8'h80) ? 8'h50 : 8'h70, "clamp");
        end
        $display("Test done: clamps");
        // Realtime run never completes; over-current aborts and interrupts
        startRun(2'd0, 1'b0);
        chkWord(uvThreshold, 3'h5, "uv field");
        pulse(0);
        watch(0, 1'b1, 1, "rt keeps running");
        pulse(1);
        mStatus = 1;
        watch(0, 1'b0, 0, "oc abort");
        watch(2, 1'b1, 0, "irq low");
        chkBit(irqSeen, 1'b1, "host sees irq");
        chkBit(pinOut, 1'b0, "pin pulls low");
        rdStatus();
        watch(2, 1'b0, 0, "irq released");
        chkBit(irqSeen, 1'b0, "pin pulled up");
        rdStatus();
        $display("Test done: oc");
        // Sequencer finishes, brakes while moving
        bemfMoving <= 1'b1;
        startRun(2'd1, 1'b1);
        pulse(0);
        mStatus = 8;
        watch(1, 1'b1, 0, "brake");
        watch(0, 1'b0, 0, "run end");
        bemfMoving <= 1'b0;
        watch(1, 1'b0, 0, "brake end");
        rdStatus();
        // Stop by go=0 brakes, no done
        bemfMoving <= 1'b1;
        startRun(2'd1, 1'b1);
        apb(1'b1, `PPC_ADDR_CTRL, cw(1'b0, 2'd1, 2'd2, 1'b1));
        watch(1, 1'b1, 0, "stop brake");
        bemfMoving <= 1'b0;
        watch(1, 1'b0, 0, "stop idle");
        rdStatus();
        // Open loop brakes only with its own enable
        bemfMoving <= 1'b1;
        apb(1'b1, `PPC_ADDR_CTRL, cw(1'b1, 2'd1, 2'd2, 1'b1) ^ 32'h10);
        watch(0, 1'b1, 0, "open run");
        apb(1'b1, `PPC_ADDR_CTRL, cw(1'b0, 2'd1, 2'd2, 1'b1) ^ 32'h10);
        watch(1, 1'b0, 1, "open no brake");
        chkBit(runEn, 1'b0, "open stop");
        apb(1'b1, `PPC_ADDR_CTRL, cw(1'b1, 2'd1, 2'd2, 1'b1) ^ 32'h110);
        watch(0, 1'b1, 0, "open run 2");
        apb(1'b1, `PPC_ADDR_CTRL, cw(1'b0, 2'd1, 2'd2, 1'b1) ^ 32'h110);
        watch(1, 1'b1, 0, "open brake");
        bemfMoving <= 1'b0;
        watch(1, 1'b0, 0, "open brake end");
        $display("Test done: done and stop");
        // Masked undervoltage in diagnostics: no brake, no interrupt
        bemfMoving <= 1'b1;
        apb(1'b1, `PPC_ADDR_MASK, 32'h4);
        startRun(2'd2, 1'b1);
        pulse(2);
        mStatus = 4;
        watch(1, 1'b0, 1, "uv no brake");
        chkBit(runEn, 1'b0, "uv abort");
        watch(2, 1'b0, 1, "masked");
        rdStatus();
        bemfMoving <= 1'b0;
        apb(1'b1, `PPC_ADDR_MASK, 32'h0);
        // Calibration aborted by a mode change
        startRun(2'd3, 1'b0);
        apb(1'b1, `PPC_ADDR_CTRL, cw(1'b1, 2'd1, 2'd2, 1'b0));
        watch(0, 1'b0, 0, "cfg abort");
        rdStatus();
        $display("Test done: aborts");
        // Fault present on entry: no routine
        overTemp <= 1'b1;
        apb(1'b1, `PPC_ADDR_CTRL, cw(1'b1, 2'd1, 2'd2, 1'b0));
        watch(0, 1'b0, 1, "entry check");
        overTemp <= 1'b0;
        mStatus = 2;
        rdStatus();
        // Standby ignores over-current, but undervoltage counts during bus
        overCurrent <= 1'b1;
        repeat (4) @(posedge clk);
        overCurrent <= 1'b0;
        uvDetect <= 1'b1;
        rdChk(`PPC_ADDR_MASK, 32'h0, "bus under uv");
        uvDetect <= 1'b0;
        mStatus = 4;
        rdStatus();
        // Pin code 3 refused
        apb(1'b1, `PPC_ADDR_CTRL, cw(1'b0, 2'd1, 2'd3, 1'b0));
        rdChk(`PPC_ADDR_CTRL, cw(1'b0, 2'd1, 2'd2, 1'b0), "pin code");
        $display("Test done: standby");
        // Pulse then level trigger from the host
        apb(1'b1, `PPC_ADDR_CTRL, cw(1'b0, 2'd1, 2'd0, 1'b0));
        trigOn <= 1'b1;
        pulse(3);
        watch(0, 1'b1, 0, "pulse start");
        pulse(3);
        watch(0, 1'b0, 0, "pulse stop");
        apb(1'b1, `PPC_ADDR_CTRL, cw(1'b0, 2'd1, 2'd1, 1'b0));
        trigLevel <= 1'b1;
        watch(0, 1'b1, 0, "level start");
        trigLevel <= 1'b0;
        watch(0, 1'b0, 0, "level stop");
        $display("Test done: triggers");
        // Shutdown in mid-run; host lets go of the pin once it is an output
        startRun(2'd1, 1'b0);
        trigOn <= 1'b0;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        chkBit(runEn, 1'b0, "shutdown abort");
        rdChk(`PPC_ADDR_CTRL, 32'h0, "ctrl default");
        chkWord(clampLevel, 8'hff, "clamp default");
        $display("Test done: shutdown");
        complete_run();
    end
endmodule // ppc_top_test
`default_nettype wire
